// File: shared/simmux_pkg.sv
// Register offsets, field positions and reset values of the card-slot register bank
package simmux_pkg;
  // Command byte of each register
  localparam logic [7:0] IDX_HW_IDENT = 8'h00;
  localparam logic [7:0] IDX_DRV_VER = 8'h01;
  localparam logic [7:0] IDX_STATUS = 8'h04;
  localparam logic [7:0] IDX_SLOT_CTRL = 8'h08;
  localparam logic [7:0] IDX_BSI_DEB = 8'h0a;
  localparam logic [7:0] IDX_SDN_DEB = 8'h0b;
  localparam logic [7:0] IDX_UNUSED = 8'h0c;
  localparam logic [7:0] IDX_CLK_SRC = 8'h0d;
  localparam logic [7:0] IDX_DEV_CTRL = 8'h0e;
  localparam logic [7:0] IDX_PULL_CTRL = 8'h15;
  // Power-up values
  localparam logic [7:0] RST_DRV_VER = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_SLOT_CTRL = 8'h00;
  localparam logic [7:0] RST_DEBOUNCE = 8'h04;
  localparam logic [7:0] RST_CLK_SRC = 8'h00;
  localparam logic [7:0] RST_DEV_CTRL = 8'h00;
  localparam logic [1:0] RST_PULL_CTRL = 2'h0;
  // Status register fields
  localparam int ST_SDN_LVL = 0;
  localparam int ST_SDN_INT = 1;
  localparam int ST_BAT_LVL = 2;
  localparam int ST_BAT_INT = 3;
  // Slot power control fields: slot 1 low nibble, slot 2 high nibble
  localparam int SC_S1_REG_EN = 0;
  localparam int SC_S1_STATE = 2;
  localparam int SC_S2_REG_EN = 4;
  localparam int SC_S2_STATE = 6;
  // Detection control and clock source fields
  localparam int DC_BAT_INT_EN = 2;
  localparam int DC_SDN_INT_EN = 5;
  localparam int CLK_SRC_BIT = 7;
  // Serial port framing
  localparam logic [3:0] BYTE_BITS = 4'h8;
endpackage

// File: rtl/simmux_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module simmux_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second, to let metastability settle
  // Reset value matches the idle pin level, so no false edge follows reset
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// File: rtl/simmux_regs.sv
// Serial-port register bank of the dual card-slot multiplexer
// What this block does
// - Read-only hardware ident at command 00h
// - Ident holds maker and device, fixed
// - Maker part unchanged across hardware revisions
// - Maker identifier sits in upper nibble
// - Maker identifier unique to the maker
// - Read-only driver version at command 01h
// - Driver version names required host software
// - Driver version changes only for software impact
// - Driver version reads zero initially
// - Status interrupt bits clear on read
// - Slot status from state and regulator bits
`timescale 1ns/1ps
module simmux_regs import simmux_pkg::*; #(
  parameter logic [6:0] SLAVE_ADDR = 7'h50,
  parameter logic [3:0] MAKER_ID = 4'ha,  // Arbitrary value
  parameter logic [3:0] DEVICE_REV = 4'h1,  // Arbitrary value
  parameter logic [7:0] DRV_VERSION = RST_DRV_VER
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic slot_shutdown_input_in,
  input wire logic battery_sense_input_in,
  output logic [7:0] slot_ctrl_out,
  output logic [7:0] bsi_debounce_out,
  output logic [7:0] sdn_debounce_out,
  output logic clk_src_out,
  output logic [7:0] dev_ctrl_out,
  output logic [1:0] pull_ctrl_out
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_CMD, ST_WR, ST_DACK, ST_RD, ST_RACK} simmux_st_t;

  localparam logic [7:0] HW_IDENT = {MAKER_ID, DEVICE_REV};

  logic [3:0] pins_s;
  logic scl_s, sda_s, sdn_s, bat_s;
  logic scl_p, sda_p, sdn_p, bat_p;
  logic scl_rise, scl_fall, start, stop, rd_load, st_clr;
  logic sdn_evt, bat_evt;
  simmux_st_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, ptr_q, wr_idx_q, wr_dat_q, rd_mux, status_w;
  logic rw_q, mack_q, wr_stb_q, oe_q, sda_lo_q;
  logic [7:0] slot_ctrl_q, bsi_deb_q, sdn_deb_q, dev_ctrl_q;
  logic clk_src_q;
  logic [1:0] pull_q;
  logic sdn_int_q, bat_int_q;

  // All pins cross into the system clock through two flops
  simmux_sync #(.W(4), .RST_VAL(4'hc)) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in({scl_in, sda_in, slot_shutdown_input_in, battery_sense_input_in}),
    .sync_out(pins_s)
  );
  assign {scl_s, sda_s, sdn_s, bat_s} = pins_s;

  // Delayed copies for edge and bus-condition detection
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      sdn_p <= 1'b0;
      bat_p <= 1'b0;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
      sdn_p <= sdn_s;
      bat_p <= bat_s;
    end
  end

  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start = scl_s & scl_p & sda_p & ~sda_s;
  assign stop = scl_s & scl_p & ~sda_p & sda_s;
  // A byte is fetched right after address ack (read) or after master ack
  assign rd_load = scl_fall & (((st_q == ST_AACK) & rw_q) | ((st_q == ST_RACK) & mack_q));
  assign st_clr = rd_load & (ptr_q == IDX_STATUS);

  // Slot status: powered-down code whenever the regulator is off
  function automatic logic [1:0] slot_code(input logic reg_en, input logic [1:0] state);
    slot_code = !reg_en ? 2'b00 : ((state == 2'b00) ? 2'b10 : state);
  endfunction

  assign status_w = {slot_code(slot_ctrl_q[SC_S2_REG_EN], slot_ctrl_q[SC_S2_STATE +: 2]),
                     slot_code(slot_ctrl_q[SC_S1_REG_EN], slot_ctrl_q[SC_S1_STATE +: 2]),
                     bat_int_q, bat_s, sdn_int_q, sdn_s};

  // Read multiplexer; reserved, test and unmapped commands read zero
  always_comb begin
    unique case (ptr_q)
      IDX_HW_IDENT: rd_mux = HW_IDENT;
      IDX_DRV_VER: rd_mux = DRV_VERSION;
      IDX_STATUS: rd_mux = status_w;
      IDX_SLOT_CTRL: rd_mux = slot_ctrl_q;
      IDX_BSI_DEB: rd_mux = bsi_deb_q;
      IDX_SDN_DEB: rd_mux = sdn_deb_q;
      IDX_CLK_SRC: rd_mux = {clk_src_q, 7'h00};
      IDX_DEV_CTRL: rd_mux = dev_ctrl_q;
      IDX_PULL_CTRL: rd_mux = {6'h00, pull_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // Serial slave: address, command byte, then data with auto-increment
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      oe_q <= 1'b0;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      ptr_q <= 8'h00;
      wr_stb_q <= 1'b0;
      wr_idx_q <= 8'h00;
      wr_dat_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (start) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (stop) begin
        st_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else begin
        unique case (st_q)
          ST_IDLE: cnt_q <= 4'h0;
          ST_ADDR, ST_CMD, ST_WR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == BYTE_BITS) begin
              cnt_q <= 4'h0;
              if (st_q == ST_ADDR) begin
                if (shift_q[7:1] == SLAVE_ADDR) begin
                  oe_q <= 1'b1;
                  rw_q <= shift_q[0];
                  st_q <= ST_AACK;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else begin
                oe_q <= 1'b1;
                st_q <= ST_DACK;
                if (st_q == ST_CMD) begin
                  ptr_q <= shift_q;
                end else begin
                  wr_stb_q <= 1'b1;
                  wr_idx_q <= ptr_q;
                  wr_dat_q <= shift_q;
                  ptr_q <= ptr_q + 8'h01;
                end
              end
            end
          end
          ST_AACK: begin
            if (scl_fall && !rw_q) begin
              oe_q <= 1'b0;
              st_q <= ST_CMD;
            end
          end
          ST_DACK: begin
            if (scl_fall) begin
              oe_q <= 1'b0;
              st_q <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == BYTE_BITS) begin
                oe_q <= 1'b0;
                st_q <= ST_RACK;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                oe_q <= ~shift_q[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_s;
            end else if (scl_fall && !mack_q) begin
              st_q <= ST_IDLE;
            end
          end
        endcase
        // Load the next read byte; pulling low drives a zero
        if (rd_load) begin
          st_q <= ST_RD;
          shift_q <= rd_mux;
          oe_q <= ~rd_mux[7];
          cnt_q <= 4'h0;
          ptr_q <= ptr_q + 8'h01;
        end
      end
    end
  end

  // Writable registers; ident, version, status, reserved and test range drop writes
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      slot_ctrl_q <= RST_SLOT_CTRL;
      bsi_deb_q <= RST_DEBOUNCE;
      sdn_deb_q <= RST_DEBOUNCE;
      clk_src_q <= RST_CLK_SRC[CLK_SRC_BIT];
      dev_ctrl_q <= RST_DEV_CTRL;
      pull_q <= RST_PULL_CTRL;
    end else if (wr_stb_q) begin
      unique case (wr_idx_q)
        IDX_SLOT_CTRL: slot_ctrl_q <= wr_dat_q;
        IDX_BSI_DEB: bsi_deb_q <= wr_dat_q;
        IDX_SDN_DEB: sdn_deb_q <= wr_dat_q;
        IDX_CLK_SRC: clk_src_q <= wr_dat_q[CLK_SRC_BIT];
        IDX_DEV_CTRL: dev_ctrl_q <= wr_dat_q;
        IDX_PULL_CTRL: pull_q <= wr_dat_q[1:0];
        default: ;
      endcase
    end
  end

  // Sticky interrupt flags; a new event beats the clear of a read
  assign sdn_evt = (sdn_s ^ sdn_p) & dev_ctrl_q[DC_SDN_INT_EN];
  assign bat_evt = bat_s & ~bat_p & dev_ctrl_q[DC_BAT_INT_EN];
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sdn_int_q <= RST_STATUS[ST_SDN_INT];
      bat_int_q <= RST_STATUS[ST_BAT_INT];
    end else begin
      sdn_int_q <= sdn_evt | (sdn_int_q & ~st_clr);
      bat_int_q <= bat_evt | (bat_int_q & ~st_clr);
    end
  end

  // Data line is open drain: the output level is always low
  always_ff @(posedge clk_sys_in) begin
    sda_lo_q <= 1'b0;
  end

  assign sda_out = sda_lo_q;
  assign sda_oe_out = oe_q;
  assign slot_ctrl_out = slot_ctrl_q;
  assign bsi_debounce_out = bsi_deb_q;
  assign sdn_debounce_out = sdn_deb_q;
  assign clk_src_out = clk_src_q;
  assign dev_ctrl_out = dev_ctrl_q;
  assign pull_ctrl_out = pull_q;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence s_load_at(logic [7:0] idx);
    rd_load && ptr_q == idx;
  endsequence

  hw_ident_read_a: assert property (s_load_at(IDX_HW_IDENT) |=> shift_q == HW_IDENT)
    else $error("hardware ident read wrong");
  maker_nibble_a: assert property (s_load_at(IDX_HW_IDENT) |=> shift_q[7:4] == MAKER_ID)
    else $error("maker nibble not in upper bits");
  drv_version_zero_a: assert property (s_load_at(IDX_DRV_VER) |=> shift_q == 8'h00 && oe_q)
    else $error("driver version not zero");
  status_clear_a: assert property (rd_load && ptr_q == IDX_STATUS && !sdn_evt && !bat_evt |=> !sdn_int_q && !bat_int_q)
    else $error("interrupt bits not cleared by read");
  event_wins_a: assert property (bat_evt |=> bat_int_q)
    else $error("battery event lost");
  slot_off_code_a: assert property (!slot_ctrl_q[SC_S1_REG_EN] |-> status_w[5:4] == 2'b00)
    else $error("slot 1 status not powered down");
  slot_iso_code_a: assert property (slot_ctrl_q[SC_S2_REG_EN] && slot_ctrl_q[7:6] == 2'b01 |-> status_w[7:6] == 2'b01)
    else $error("slot 2 isolated code wrong");
  ro_write_drop_a: assert property (wr_stb_q && wr_idx_q == IDX_STATUS |=> $stable(slot_ctrl_q) && $stable(dev_ctrl_q))
    else $error("read-only write changed state");
  debounce_reset_a: assert property ($fell(rst_in) |-> bsi_deb_q == 8'h04 && sdn_deb_q == 8'h04)
    else $error("debounce counters not four after reset");
  ctrl_write_a: assert property (wr_stb_q && wr_idx_q == IDX_SLOT_CTRL |=> slot_ctrl_q == $past(wr_dat_q))
    else $error("slot control write lost");
endmodule

// File: tb/simmux_host.sv
// Serial host model that drives the clock and data pins of the register bank
`timescale 1ns/1ps
module simmux_host (
  input wire logic clk_sys_in,
  input wire logic sda_line_in,
  output logic scl_out,
  output logic sda_low_out
);
  // Each phase lasts 8 system cycles, four times the port's two-flop synchroniser
  task automatic half();
    repeat (8) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic put_bit(input logic b);
    sda_low_out = ~b;
    half();
    scl_out = 1'b1;
    half();
    scl_out = 1'b0;
  endtask
  // Data is taken late in the high phase, long after the device has settled
  task automatic get_bit(output logic b);
    sda_low_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    b = sda_line_in;
    scl_out = 1'b0;
  endtask
  // Works from idle and as a repeated start after an ack slot
  task automatic start();
    sda_low_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_low_out = 1'b1;
    half();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_low_out = 1'b0;
    half();
  endtask
  // Byte out, MSB first; ack is high when the port pulled the line low
  task automatic send(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      put_bit(v[i]);
    get_bit(b);
    ack = ~b;
  endtask
  task automatic recv(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      get_bit(v[i]);
    put_bit(last);
  endtask
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
endmodule

// File: tb/simmux_regs_bench.sv
// Self-checking bench of the card-slot register bank
`timescale 1ns/1ps
module simmux_regs_bench import simmux_pkg::*;;
  localparam logic [6:0] ADDR = 7'h50;
  localparam logic [3:0] MAKER = 4'h5; // Arbitrary value
  localparam logic [3:0] REV = 4'h3; // Arbitrary value
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic scl, host_low, dut_low, sda_line, dut_sda, sdn_pin, bat_pin, clk_src, ack;
  logic [7:0] slot_ctrl, bsi_deb, sdn_deb, dev_ctrl, rd, v;
  logic [1:0] pull;
  int bad_count = 0;
  int samples_checked = 0;
  // Pulled-up data line, low while either side pulls
  assign sda_line = ~(host_low | dut_low);
  always #2.5 clk_sys_in = ~clk_sys_in;
  simmux_regs #(.SLAVE_ADDR(ADDR), .MAKER_ID(MAKER), .DEVICE_REV(REV)) i_dut (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line), .sda_out(dut_sda), .sda_oe_out(dut_low),
    .slot_shutdown_input_in(sdn_pin), .battery_sense_input_in(bat_pin), .slot_ctrl_out(slot_ctrl),
    .bsi_debounce_out(bsi_deb), .sdn_debounce_out(sdn_deb), .clk_src_out(clk_src),
    .dev_ctrl_out(dev_ctrl), .pull_ctrl_out(pull));
  simmux_host i_host (.clk_sys_in(clk_sys_in), .sda_line_in(sda_line), .scl_out(scl), .sda_low_out(host_low));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Command byte then one data byte; only mapped places are written
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    i_host.start();
    i_host.send({ADDR, 1'b0}, ack);
    i_host.send(idx, ack);
    i_host.send(d, ack);
    check("write ack", {7'h0, ack}, 8'h01);
    i_host.stop();
  endtask
  // Pointer set by a write, then a repeated start and a single read
  task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    i_host.start();
    i_host.send({ADDR, 1'b0}, ack);
    i_host.send(idx, ack);
    i_host.start();
    i_host.send({ADDR, 1'b1}, ack);
    i_host.recv(1'b1, rd);
    i_host.stop();
    check(what, rd, exp);
  endtask
  task automatic do_reset();
    rst_in = 1'b1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    repeat (4) @(posedge clk_sys_in);
    #1;
    check("slot ctrl", slot_ctrl, RST_SLOT_CTRL);
    check("bsi debounce", bsi_deb, 8'h04);
    check("sdn debounce", sdn_deb, 8'h04);
    check("clk source", {7'h0, clk_src}, 8'h00);
    check("dev ctrl", dev_ctrl, 8'h00);
    check("pull ctrl", {6'h0, pull}, 8'h00);
    check("sda drive", {7'h0, dut_sda}, 8'h00);
    check("sda enable", {7'h0, dut_low}, 8'h00);
  endtask
  // Slot status: off reads 00, on with state 00 reads 10, else the state
  function automatic logic [1:0] slot_st(input logic [3:0] n);
    return n[0] ? ((n[3:2] == 2'b00) ? 2'b10 : n[3:2]) : 2'b00;
  endfunction
  localparam logic [7:0] W_IDX [5] = '{8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h15};
  localparam logic [7:0] W_VAL [5] = '{8'hff, 8'h01, 8'h80, 8'h24, 8'h03};
  initial begin
    sdn_pin = 1'b0;
    bat_pin = 1'b0;
    do_reset();
    rchk("ident", 8'h00, {MAKER, REV});
    rchk("driver version", 8'h01, 8'h00);
    rchk("status", 8'h04, 8'h00);
    // Writes to read-only places must leave them untouched
    wr(8'h00, 8'hff);
    wr(8'h01, 8'hff);
    wr(8'h04, 8'hff);
    rchk("ident", 8'h00, {MAKER, REV});
    rchk("driver version", 8'h01, 8'h00);
    rchk("status", 8'h04, 8'h00);
    rchk("reserved", 8'h0c, 8'h00);
    for (int k = 0; k < 5; k++) begin
      wr(W_IDX[k], W_VAL[k]);
      rchk("writable", W_IDX[k], W_VAL[k]);
    end
    check("bsi out", bsi_deb, 8'hff);
    check("sdn out", sdn_deb, 8'h01);
    check("clk out", {7'h0, clk_src}, 8'h01);
    check("dev out", dev_ctrl, 8'h24);
    check("pull out", {6'h0, pull}, 8'h03);
    // Every state and regulator combination of each slot
    for (int k = 0; k < 16; k++) begin
      v = {4'(k), 4'(15 - k)};
      wr(8'h08, v);
      check("slot out", slot_ctrl, v);
      rchk("slot status", 8'h04, {slot_st(v[7:4]), slot_st(v[3:0]), 4'h0});
    end
    // Interrupt bits set by pin events and cleared by the read
    wr(8'h08, 8'h00);
    @(posedge clk_sys_in);
    #1;
    sdn_pin = 1'b1;
    bat_pin = 1'b1;
    repeat (10) @(posedge clk_sys_in);
    rchk("status irq", 8'h04, 8'h0f);
    rchk("status cleared", 8'h04, 8'h05);
    // With detection disabled only the levels show
    wr(8'h0e, 8'h00);
    @(posedge clk_sys_in);
    #1;
    sdn_pin = 1'b0;
    bat_pin = 1'b0;
    repeat (10) @(posedge clk_sys_in);
    #1;
    bat_pin = 1'b1;
    repeat (10) @(posedge clk_sys_in);
    rchk("status masked", 8'h04, 8'h04);
    do_reset();
    final_report();
  end
  // Whole run is near 33000 cycles
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    bad_count++;
    final_report();
  end
endmodule
